// File: dv/tpo_timer_tb_top.sv
/*
 * self-checking bench of the timer output stage: register port, pwm
 * waveform with its buffers, one-shot pulse, interrupt flags, disable.
 * assumes the register map, strobes and pin timing of the design package.
 */
`timescale 1ns/1ns
module tpo_timer_tb_top
    import tpo_pkg::*;
;
    // clock, reset and register port
    logic              CLK;
    logic              ARST_N;
    logic [ADDR_W-1:0] ADDR;
    logic [DATA_W-1:0] WDATA;
    logic              WR;
    logic              RD;
    // observed outputs
    logic [DATA_W-1:0] RDATA;
    logic              TOGGLE_OUT_PIN;
    logic              PWM_OUT_PIN;
    logic              MATCH0_IRQ;
    logic              MATCH1_IRQ;
    logic              IRQ;
    // verdict counters and hang guard
    int                num_errors = 0;
    int                tests_run  = 0;
    int                cyc        = 0;

    tpo_timer dut_u (
        .CLK            (CLK),
        .ARST_N         (ARST_N),
        .ADDR           (ADDR),
        .WDATA          (WDATA),
        .WR             (WR),
        .RD             (RD),
        .RDATA          (RDATA),
        .TOGGLE_OUT_PIN (TOGGLE_OUT_PIN),
        .PWM_OUT_PIN    (PWM_OUT_PIN),
        .MATCH0_IRQ     (MATCH0_IRQ),
        .MATCH1_IRQ     (MATCH1_IRQ),
        .IRQ            (IRQ)
    );

    // 50 MHz clock
    initial CLK = 1'b0;
    always #10 CLK = ~CLK;

    // whole run needs under a thousand cycles; a hang ends it as a failure
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // compare of a 16-bit word
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // compare of a single pin or flag
    task automatic chk1(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    // one-cycle write strobe, launched and dropped right after edges
    task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [2:0] a, input logic [15:0] exp);
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD   <= 1'b0;
        @(negedge CLK);
        chk16(what, exp, RDATA);
        // read data must fall back to zero once its cycle is over
        @(negedge CLK);
        chk16("read data idle", 16'h0000, RDATA);
    endtask

    // waits for the next period clear, bounded
    task automatic wait_m0;
        int t;
        t = 0;
        @(negedge CLK);
        while (MATCH0_IRQ !== 1'b1 && t < 3000) begin
            @(negedge CLK);
            t++;
        end
        chk1("match0 seen", 1'b1, MATCH0_IRQ);
    endtask

    // counter model synced at a clear, then n whole periods compared
    task automatic pwm_check(input int per, input int du, input int ps, input int n);
        int   cnt, sub;
        logic tg;
        wait_m0();
        cnt = 0;
        sub = 0;
        tg  = TOGGLE_OUT_PIN;
        repeat (n * ((per + 1) << ps)) begin
            @(negedge CLK);
            sub++;
            // one count per prescaled tick, wrap after the period value
            if (sub == (1 << ps)) begin
                sub = 0;
                cnt = (cnt == per) ? 0 : cnt + 1;
                if (cnt == 0)
                    tg = ~tg;
            end
            chk1("pwm pin", cnt < du, PWM_OUT_PIN);
            chk1("match1 pulse", sub == 0 && cnt == du, MATCH1_IRQ);
            chk1("match0 pulse", sub == 0 && cnt == 0, MATCH0_IRQ);
            chk1("toggle pin", tg, TOGGLE_OUT_PIN);
        end
    endtask

    initial begin
        int          per, du, ps, i0, i1, nh, n0, n1;
        logic [15:0] v;
        ADDR   = '0;
        WDATA  = '0;
        WR     = 1'b0;
        RD     = 1'b0;
        ARST_N = 1'b0;
        void'($urandom(34));
        repeat (5) @(posedge CLK);
        ARST_N <= 1'b1;
        @(negedge CLK);
        chk1("idle outputs", 1'b0, PWM_OUT_PIN | TOGGLE_OUT_PIN | MATCH0_IRQ | MATCH1_IRQ | IRQ);
        // values after reset, counter parked at ffff, index 7 empty
        for (int i = 0; i < 8; i++)
            rd_chk("reset value", 3'(i), (i == 6) ? CNT_IDLE : 16'h0000);
        // random read-back of period, duty and edge select (8 bits)
        for (int i = 1; i < 4; i++) begin
            v = 16'($urandom);
            reg_wr(3'(i), v);
            rd_chk("reg rw", 3'(i), (i == 3) ? {8'h00, v[7:0]} : v);
        end
        // counter is read only, index 7 ignores writes
        reg_wr(IDX_COUNT, 16'h1234);
        rd_chk("count ro", IDX_COUNT, CNT_IDLE);
        reg_wr(3'h7, 16'h5a5a);
        rd_chk("unmapped", 3'h7, 16'h0000);
        // random pwm setups, duty from 0% up to 100%
        for (int i = 0; i < 3; i++) begin
            per = 2 + $urandom % 8;
            du  = $urandom % (per + 2);
            ps  = $urandom % 3;
            reg_wr(IDX_PERIOD, 16'(per));
            reg_wr(IDX_DUTY, 16'(du));
            reg_wr(IDX_CTRL, 16'h0009 | 16'(ps << 5));
            pwm_check(per, du, ps, 2);
            reg_wr(IDX_CTRL, 16'h0000);
        end
        // buffer reload only after a duty write, at the clear
        reg_wr(IDX_PERIOD, 16'h0003);
        reg_wr(IDX_DUTY, 16'h0002);
        reg_wr(IDX_CTRL, 16'h0009);
        pwm_check(3, 2, 0, 1);
        wait_m0();
        reg_wr(IDX_PERIOD, 16'h0005);
        pwm_check(3, 2, 0, 2);
        wait_m0();
        reg_wr(IDX_DUTY, 16'h0004);
        pwm_check(5, 4, 0, 2);
        wait_m0();
        reg_wr(IDX_DUTY, 16'h0000);
        pwm_check(5, 0, 0, 2);
        wait_m0();
        reg_wr(IDX_DUTY, 16'h0006);
        pwm_check(5, 6, 0, 2);
        // disable while the pin is held high
        reg_wr(IDX_CTRL, 16'h0000);
        repeat (2) @(negedge CLK);
        chk1("pins off", 1'b0, PWM_OUT_PIN | TOGGLE_OUT_PIN);
        repeat (20) begin
            @(negedge CLK);
            chk1("no events", 1'b0, MATCH0_IRQ | MATCH1_IRQ);
        end
        rd_chk("count stop", IDX_COUNT, CNT_IDLE);
        // sticky flags, mask and write-one-to-clear
        rd_chk("status", IDX_STAT, 16'h0003);
        chk1("irq masked", 1'b0, IRQ);
        reg_wr(IDX_MASK, 16'h0001);
        @(negedge CLK);
        chk1("irq on", 1'b1, IRQ);
        reg_wr(IDX_STAT, 16'h0001);
        @(negedge CLK);
        chk1("irq cleared", 1'b0, IRQ);
        reg_wr(IDX_MASK, 16'h0002);
        @(negedge CLK);
        chk1("irq match1", 1'b1, IRQ);
        reg_wr(IDX_STAT, 16'h0002);
        rd_chk("status clear", IDX_STAT, 16'h0000);
        // one-shot with the start compare raised live after the trigger;
        // only raised, since a lowered compare could be overrun and wrap
        reg_wr(IDX_PERIOD, 16'd60);
        reg_wr(IDX_DUTY, 16'd5);
        reg_wr(IDX_CTRL, 16'h0007);
        reg_wr(IDX_CTRL, 16'h0017);
        reg_wr(IDX_DUTY, 16'd12);
        i0 = 0;
        i1 = 0;
        n0 = 0;
        n1 = 0;
        nh = 0;
        for (int i = 0; i < 120; i++) begin
            @(negedge CLK);
            if (MATCH1_IRQ === 1'b1) begin
                n1++;
                i1 = i;
            end
            if (MATCH0_IRQ === 1'b1) begin
                n0++;
                i0 = i;
            end
            if (PWM_OUT_PIN === 1'b1)
                nh++;
        end
        chk16("oneshot match1 count", 16'h0001, 16'(n1));
        chk16("oneshot match0 count", 16'h0001, 16'(n0));
        chk16("live compare used", 16'd11, 16'(i1));
        chk16("oneshot span", 16'd48, 16'(i0 - i1));
        chk16("oneshot width", 16'd48, 16'(nh));
        rd_chk("oneshot stop", IDX_COUNT, CNT_IDLE);
        wrap_up();
    end
endmodule

// File: rtl/tpo_irq.sv
/*
 * sticky interrupt status with write-one-to-clear and a mask register.
 * assumes events are one-cycle pulses; a set in the clear cycle wins.
 */
`timescale 1ns/1ns
module tpo_irq
    import tpo_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // events from the counter
    input  wire tpo_evt_t   evt,
    // software access
    input  wire logic       stat_we,
    input  wire logic       mask_we,
    input  wire logic [1:0] wdata,
    // state and request
    output logic      [1:0] status,
    output logic      [1:0] mask,
    output logic            irq
);

    logic [1:0] stat_q;  // sticky flags
    logic [1:0] stat_d;
    logic [1:0] mask_q;  // enables
    logic [1:0] mask_d;

    // clear by ones written, then set; set wins so no event is lost
    always_comb begin
        stat_d = stat_q;
        mask_d = mask_q;
        if (stat_we) begin
            stat_d = stat_d & ~wdata;
        end
        stat_d = stat_d | evt;
        if (mask_we) begin
            mask_d = wdata;
        end
    end

    // flag and mask registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_q <= RST_IRQ;
            mask_q <= RST_IRQ;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    assign status = stat_q;
    assign mask   = mask_q;
    assign irq    = |(stat_q & mask_q);

endmodule

// File: rtl/tpo_pkg.sv
/*
 * shared constants and types of the timer pwm / one-shot output block:
 * register indices, field positions, reset values, mode codes, states.
 * assumes a plain single-cycle register port with 3-bit word index.
 */
package tpo_pkg;

    // widths
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W  = 16;
    localparam int unsigned PS_W   = 3;
    localparam int unsigned DIV_W  = 7;

    // register indices on the plain port
    localparam logic [2:0] IDX_CTRL   = 3'h0;
    localparam logic [2:0] IDX_PERIOD = 3'h1;
    localparam logic [2:0] IDX_DUTY   = 3'h2;
    localparam logic [2:0] IDX_EDGE   = 3'h3;
    localparam logic [2:0] IDX_STAT   = 3'h4;
    localparam logic [2:0] IDX_MASK   = 3'h5;
    localparam logic [2:0] IDX_COUNT  = 3'h6;

    // field positions in timer_control_reg
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_MODE_LSB = 1;
    localparam int unsigned CTRL_TRIG_BIT = 4;
    localparam int unsigned CTRL_PS_LSB   = 5;

    // timer_mode_field codes; the one-shot code is a plain default
    localparam logic [2:0] MODE_PWM     = 3'h4;
    localparam logic [2:0] MODE_ONESHOT = 3'h3;

    // counter values
    localparam logic [15:0] CNT_IDLE = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    // values after reset
    localparam logic [7:0]  RST_CTRL = 8'h00;
    localparam logic [15:0] RST_CMP  = 16'h0000;
    localparam logic [7:0]  RST_EDGE = 8'h00;
    localparam logic [1:0]  RST_IRQ  = 2'h0;
    localparam logic [6:0]  RST_DIV  = 7'h00;

    // the two compare match events, bit 0 = match0, bit 1 = match1
    typedef struct packed {
        logic match1;
        logic match0;
    } tpo_evt_t;

    // counter states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ONESHOT,
        ST_PWM
    } tpo_state_t;

    // counter increment with wrap from ffff to 0000
    function automatic logic [15:0] tpo_inc(input logic [15:0] v);
        tpo_inc = 16'(v + 16'h0001);
    endfunction

    // register index decode
    function automatic logic tpo_hit(input logic [2:0] a, input logic [2:0] idx);
        tpo_hit = (a == idx);
    endfunction

endpackage

// File: rtl/tpo_prescale.sv
/*
 * count clock divider: one-cycle tick every 2**ps system clocks.
 * assumes run is low while the counter is stopped; the divider restarts on run.
 */
`timescale 1ns/1ns
module tpo_prescale
    import tpo_pkg::*;
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            arst_n,
    // control
    input  wire logic            run,
    input  wire logic [PS_W-1:0] ps,
    // count clock enable
    output logic                 tick
);

    logic [DIV_W-1:0] div_q;  // divider count
    logic [DIV_W-1:0] div_d;
    logic [DIV_W-1:0] lim;    // terminal count for this rate

    // terminal count and next divider value
    always_comb begin
        lim   = DIV_W'((8'h01 << ps) - 8'h01);
        tick  = run && (div_q == lim);
        div_d = (!run || tick) ? RST_DIV : DIV_W'(div_q + 7'h01);
    end

    // divider register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= RST_DIV;
        end else begin
            div_q <= div_d;
        end
    end

endmodule

// File: rtl/tpo_timer.sv
/*
 * 16-bit timer output stage: one-shot pulse mode and pwm output mode,
 * register port, count clock prescaler and sticky interrupt flags.
 * assumes a single 50 MHz clock, synchronous register strobes and that
 * software follows the rewrite order of the pwm buffers.
 */
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ns

module tpo_timer
    import tpo_pkg::*;
(
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              ARST_N,
    // register port
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [DATA_W-1:0] RDATA,
    // output pins
    output logic                   TOGGLE_OUT_PIN,
    output logic                   PWM_OUT_PIN,
    // compare match pulses and interrupt
    output logic                   MATCH0_IRQ,
    output logic                   MATCH1_IRQ,
    output logic                   IRQ
);

    // software registers
    logic [7:0]        ctrl_q;       // timer_control_reg, trigger bit not stored
    logic [7:0]        ctrl_d;
    logic [CNT_W-1:0]  period_q;     // compare_period
    logic [CNT_W-1:0]  period_d;
    logic [CNT_W-1:0]  duty_q;       // compare_duty
    logic [CNT_W-1:0]  duty_d;
    logic [7:0]        edge_q;       // trigger_edge_select, stored only
    logic [7:0]        edge_d;
    logic [DATA_W-1:0] rdata_q;      // read data, valid one cycle
    logic [DATA_W-1:0] rdata_d;

    // counter group
    tpo_state_t        st_q;         // counter state
    tpo_state_t        st_d;
    logic [CNT_W-1:0]  cnt_q;        // 16-bit counter
    logic [CNT_W-1:0]  cnt_d;
    logic [CNT_W-1:0]  per_sh_q;     // period_shadow
    logic [CNT_W-1:0]  per_sh_d;
    logic [CNT_W-1:0]  duty_sh_q;    // duty_shadow
    logic [CNT_W-1:0]  duty_sh_d;
    logic              arm_q;        // buffer transfer armed
    logic              arm_d;
    logic              pwm_q;        // pwm_out_pin level
    logic              pwm_d;
    logic              tog_q;        // toggle_out_pin level
    logic              tog_d;
    tpo_evt_t          evt_q;        // registered match pulses
    tpo_evt_t          evt_d;

    // decoded controls
    logic              en;           // count_enable_bit
    logic [2:0]        mode;         // timer_mode_field
    logic [PS_W-1:0]   ps;           // count clock rate
    logic              wr_ctrl;
    logic              wr_duty;
    logic              trig;         // one-shot software trigger
    logic              tick;         // count clock enable
    logic [CNT_W-1:0]  cnt_inc;      // counter plus one
    logic [CNT_W-1:0]  duty_nx;      // duty used after a clear
    logic [1:0]        irq_stat;
    logic [1:0]        irq_mask;

    assign en      = ctrl_q[CTRL_EN_BIT];
    assign mode    = ctrl_q[CTRL_MODE_LSB +: 3];
    assign ps      = ctrl_q[CTRL_PS_LSB +: PS_W];
    assign wr_ctrl = WR && tpo_hit(ADDR, IDX_CTRL);
    assign wr_duty = WR && tpo_hit(ADDR, IDX_DUTY);
    assign trig    = wr_ctrl && WDATA[CTRL_TRIG_BIT];
    assign cnt_inc = tpo_inc(cnt_q);

    // count clock divider, held while stopped so a start is clean
    tpo_prescale u_prescale (
        .clk    (CLK),
        .arst_n (ARST_N),
        .run    (st_q != ST_IDLE),
        .ps     (ps),
        .tick   (tick)
    );

    // sticky flags for both compare events
    tpo_irq u_irq (
        .clk     (CLK),
        .arst_n  (ARST_N),
        .evt     (evt_q),
        .stat_we (WR && tpo_hit(ADDR, IDX_STAT)),
        .mask_we (WR && tpo_hit(ADDR, IDX_MASK)),
        .wdata   (WDATA[1:0]),
        .status  (irq_stat),
        .mask    (irq_mask),
        .irq     (IRQ)
    );

    // register writes and read mux; reads of index 7 give zero
    always_comb begin
        ctrl_d   = ctrl_q;
        period_d = period_q;
        duty_d   = duty_q;
        edge_d   = edge_q;
        rdata_d  = '0;
        if (wr_ctrl) begin
            ctrl_d = WDATA[7:0] & ~(8'h01 << CTRL_TRIG_BIT);
        end
        if (WR && tpo_hit(ADDR, IDX_PERIOD)) begin
            period_d = WDATA;
        end
        if (wr_duty) begin
            duty_d = WDATA;
        end
        if (WR && tpo_hit(ADDR, IDX_EDGE)) begin
            edge_d = WDATA[7:0];
        end
        if (RD) begin
            unique case (ADDR)
                IDX_CTRL:   rdata_d = {8'h00, ctrl_q};
                IDX_PERIOD: rdata_d = period_q;
                IDX_DUTY:   rdata_d = duty_q;
                IDX_EDGE:   rdata_d = {8'h00, edge_q};
                IDX_STAT:   rdata_d = {14'h0, irq_stat};
                IDX_MASK:   rdata_d = {14'h0, irq_mask};
                IDX_COUNT:  rdata_d = cnt_q;
                default:    rdata_d = '0;
            endcase
        end
    end

    // software registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_q   <= RST_CTRL;
            period_q <= RST_CMP;
            duty_q   <= RST_CMP;
            edge_q   <= RST_EDGE;
            rdata_q  <= '0;
        end else begin
            ctrl_q   <= ctrl_d;
            period_q <= period_d;
            duty_q   <= duty_d;
            edge_q   <= edge_d;
            rdata_q  <= rdata_d;
        end
    end

    // counter, buffers and pins; one counter serves both modes
    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        per_sh_d  = per_sh_q;
        duty_sh_d = duty_sh_q;
        arm_d     = arm_q;
        pwm_d     = pwm_q;
        tog_d     = tog_q;
        evt_d     = '0;
        duty_nx   = arm_q ? duty_q : duty_sh_q;
        unique case (st_q)
            ST_IDLE: begin
                // parked at ffff so the first count lands on 0000
                cnt_d     = CNT_IDLE;
                pwm_d     = 1'b0;
                tog_d     = 1'b0;
                arm_d     = 1'b0;
                per_sh_d  = period_q;
                duty_sh_d = duty_q;
                if (en && mode == MODE_PWM) begin
                    st_d = ST_PWM;
                end else if (en && mode == MODE_ONESHOT && trig) begin
                    st_d = ST_ONESHOT;
                end
            end
            ST_ONESHOT: begin
                if (tick) begin
                    // plain 16-bit wrap past a missed compare
                    cnt_d = cnt_inc;
                    if (cnt_inc == duty_q) begin
                        pwm_d        = 1'b1;
                        evt_d.match1 = 1'b1;
                    end
                    if (cnt_inc == period_q) begin
                        pwm_d        = 1'b0;
                        evt_d.match0 = 1'b1;
                        st_d         = ST_IDLE;
                    end
                end
            end
            ST_PWM: begin
                if (wr_duty) begin
                    arm_d = 1'b1;
                end
                if (tick) begin
                    if (cnt_q == per_sh_q) begin
                        cnt_d        = CNT_ZERO;
                        evt_d.match0 = 1'b1;
                        tog_d        = ~tog_q;
                        if (arm_q) begin
                            per_sh_d  = period_q;
                            duty_sh_d = duty_q;
                            arm_d     = wr_duty;
                        end
                        pwm_d        = (duty_nx != CNT_ZERO);
                        evt_d.match1 = (duty_nx == CNT_ZERO);
                    end else begin
                        cnt_d        = cnt_inc;
                        pwm_d        = (cnt_inc < duty_sh_q);
                        evt_d.match1 = (cnt_inc == duty_sh_q);
                    end
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        // disable or mode change stops at once
        if (st_q != ST_IDLE && (!en || mode != (st_q == ST_PWM ? MODE_PWM : MODE_ONESHOT))) begin
            st_d  = ST_IDLE;
            cnt_d = CNT_IDLE;
            pwm_d = 1'b0;
            tog_d = 1'b0;
            arm_d = 1'b0;
            evt_d = '0;
        end
    end

    // counter group registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_q      <= ST_IDLE;
            cnt_q     <= CNT_IDLE;
            per_sh_q  <= RST_CMP;
            duty_sh_q <= RST_CMP;
            arm_q     <= 1'b0;
            pwm_q     <= 1'b0;
            tog_q     <= 1'b0;
            evt_q     <= '0;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            per_sh_q  <= per_sh_d;
            duty_sh_q <= duty_sh_d;
            arm_q     <= arm_d;
            pwm_q     <= pwm_d;
            tog_q     <= tog_d;
            evt_q     <= evt_d;
        end
    end

    // outputs, all from flip-flops
    assign RDATA          = rdata_q;
    assign TOGGLE_OUT_PIN = tog_q;
    assign PWM_OUT_PIN    = pwm_q;
    assign MATCH0_IRQ     = evt_q.match0;
    assign MATCH1_IRQ     = evt_q.match1;

    // checks on the counter and pins
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    a_pwm_clear_wrap: assert property (
        (st_q == ST_PWM) && en && mode == MODE_PWM && tick && cnt_q == per_sh_q
        |=> cnt_q == CNT_ZERO && evt_q.match0)
        else $error("pwm counter did not clear with match0");

    a_pwm_toggle_flip: assert property (
        (st_q == ST_PWM) && en && mode == MODE_PWM && tick && cnt_q == per_sh_q
        |=> tog_q != $past(tog_q))
        else $error("toggle pin did not flip at period end");

    a_duty_match_pin: assert property (
        (st_q == ST_PWM) && evt_q.match1 |-> cnt_q == duty_sh_q && !pwm_q)
        else $error("pwm match1 not at duty value or pin still active");

    a_buffer_load_sync: assert property (
        (st_q == ST_PWM) && $changed(per_sh_q) |-> cnt_q == CNT_ZERO)
        else $error("period buffer changed away from counter clear");

    a_start_from_idle: assert property (
        $rose(st_q == ST_PWM) |-> cnt_q == CNT_IDLE ##0 !pwm_q)
        else $error("pwm start not from ffff");

    a_counter_wraps: assert property (
        (st_q == ST_ONESHOT) && en && mode == MODE_ONESHOT && tick && cnt_q == CNT_IDLE
        && period_q != CNT_ZERO |=> cnt_q == CNT_ZERO)
        else $error("counter did not wrap to 0000");

    a_oneshot_end: assert property (
        (st_q == ST_ONESHOT) && evt_d.match0 |=> st_q == ST_IDLE && !pwm_q && evt_q.match0)
        else $error("one-shot did not stop on match0");

    a_oneshot_pin_flag: assert property (
        (st_q == ST_ONESHOT) && evt_q.match1 && !evt_q.match0 |-> pwm_q && $rose(pwm_q))
        else $error("one-shot match1 not aligned with pin rise");

    a_disable_quiet: assert property (
        !en |=> st_q == ST_IDLE && !pwm_q && !tog_q && evt_q == '0)
        else $error("outputs active after disable");

endmodule
